// ---- hw/chan_map_cfg.svh ----
// Purpose: Constants for the dual input channel mapper.
// Assumes: Included by its bare name from the package.
// Notes: Offsets are register indices on the plain register port.
`ifndef CHAN_MAP_CFG_SVH
`define CHAN_MAP_CFG_SVH

// Widths and counts
`define CM_CONVERTERS 16
`define CM_CHANNELS 32
`define CM_WORD_W 14
`define CM_GAIN_W 6
`define CM_OFFS_W 8
`define CM_ACC_W 20
`define CM_ACC_FRAC 6
`define CM_GROUP_SIZE 4
`define CM_GROUPS 4
`define CM_CORNER_W 3
`define CM_FIFO_DEPTH 16
`define CM_REG_AW 8
`define CM_REG_DW 16

// Gain is applied as (unity + code) / unity
`define CM_GAIN_UNITY 7'h40
`define CM_GAIN_SHIFT 6

// Register indices
`define CM_ADDR_CTRL 8'h00
`define CM_ADDR_DIG_PDN 8'h01
`define CM_ADDR_ANA_PDN 8'h02
`define CM_ADDR_IN_SEL 8'h03
`define CM_ADDR_HPF_EN 8'h04
`define CM_ADDR_HPF_CORNER 8'h05
`define CM_ADDR_STATUS 8'h06
`define CM_ADDR_FRAMES 8'h07
`define CM_ADDR_GAIN_BASE 3'h2
`define CM_ADDR_OFFS_BASE 3'h3

// Field positions
`define CM_CTRL_MODE16_BIT 0
`define CM_CTRL_RATE2X_BIT 1
`define CM_STAT_RATE_REFUSED_BIT 0
`define CM_STAT_OVERFLOW_BIT 1
`define CM_STAT_ORDER_ERR_BIT 2
`define CM_STAT_LEVEL_LSB 8

// Reset values
`define CM_CTRL_RST 2'h0
`define CM_PDN_RST 16'h0000
`define CM_IN_SEL_RST 16'h0000
`define CM_HPF_EN_RST 4'h0
`define CM_HPF_CORNER_RST 12'h000

// Serial frame lengths in bit periods, less one
`define CM_FRAME_BITS_TWO 5'h1b
`define CM_FRAME_BITS_ONE 5'h0d

`endif

// ---- hw/chan_map_pkg.sv ----
// Purpose: Types shared by the channel mapper modules.
// Assumes: chan_map_cfg.svh holds the widths.
// Notes: Frames carry an odd and an even word for every lane, except single (16-input) frames with one word.
`default_nettype none
`include "chan_map_cfg.svh"
package chan_map_pkg;
  typedef logic [`CM_WORD_W-1:0] word_t;
  typedef logic [`CM_CONVERTERS-1:0][`CM_WORD_W-1:0] conv_bus_t;
  typedef logic [`CM_GAIN_W-1:0] gain_t;
  typedef logic [`CM_OFFS_W-1:0] offs_t;
  typedef logic [`CM_ACC_W-1:0] acc_t;
  typedef struct packed {
    logic single;        // One word per lane (16-input mode)
    conv_bus_t odd_w;    // First instant words, or the one word of a single frame
    conv_bus_t even_w;   // Second instant words
  } frame_t;
  typedef struct packed {
    logic [`CM_REG_AW-1:0] addr;
    logic [`CM_REG_DW-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic mode16;
    logic rate2x;
    logic [`CM_CONVERTERS-1:0] dig_pdn;
    logic [`CM_CONVERTERS-1:0] ana_pdn;
    logic [`CM_CONVERTERS-1:0] in_sel;
    logic [`CM_GROUPS-1:0] hpf_en;
    logic [`CM_GROUPS-1:0][`CM_CORNER_W-1:0] hpf_corner;
    logic [`CM_CHANNELS-1:0][`CM_GAIN_W-1:0] gain;
    logic [`CM_CHANNELS-1:0][`CM_OFFS_W-1:0] offs;
    logic [`CM_CHANNELS-1:0][`CM_ACC_W-1:0] acc;
    conv_bus_t odd_hold;
    logic odd_seen;
    frame_t frame;
    logic frame_vld;
    logic rate_refused;
    logic overflow;
    logic order_err;
    logic [`CM_REG_DW-1:0] frames;
    logic [`CM_REG_DW-1:0] rdata;
  } map_st_t;
endpackage
`default_nettype wire

// ---- hw/chan_mapper.sv ----
// Purpose: Channel ordering and per-channel trim for 32/16-input modes.
// Assumes: Converter words arrive on sys_clk from same-domain logic.
// Notes on behaviour
// [R1] 32-input mode refuses the doubled data rate
// [R2] Each converter serves two inputs alternately
// [R3] First instant odd input, second instant even
// [R4] Converter x words go to lane x
// [R5] One frame per lane: odd then even
// [R6] Odd/even gain and offset per channel
// [R7] Digital power-down covers both converter channels
// [R8] Analog power-down covers both converter inputs
// [R9] High-pass settings shared by four-converter group
// [R10] 16-input mode: odd input, select picks even
// [R11] Odd/even ordering fixed frame to frame
//
// Implementation choices: strobed register access and the register offsets.
`default_nettype none
module chan_mapper
  import chan_map_pkg::*;
#(
  parameter int FIFO_DEPTH = `CM_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire chan_map_pkg::reg_req_t reg_req,
  output logic [`CM_REG_DW-1:0] reg_rdata,
  // Converter words, phase low at first instant
  input wire logic conv_valid,
  input wire logic conv_phase,
  input wire chan_map_pkg::conv_bus_t conv_word,
  output logic conv_ready,
  // Serial lanes toward the receiver
  output logic [`CM_CONVERTERS-1:0] serial_lane_out,
  output logic frame_sync,
  // Per-input analog power-down and high-pass enable
  output logic [`CM_CHANNELS-1:0] input_powerdown,
  output logic [`CM_CHANNELS-1:0] channel_highpass_enable
);
  import chan_map_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  map_st_t st_r;            // All registered state
  map_st_t st_nxt;          // Its next value
  logic fifo_in_ready;      // FIFO can take the held frame
  logic fifo_out_valid;     // Frame waiting for the packer
  logic packer_ready;       // Packer loads a frame
  frame_t fifo_out_data;    // Frame toward the packer
  logic [LW-1:0] fifo_level;

  // Clamp a wide signed value into a converter word
  function automatic word_t sat_word(logic signed [16:0] v);
    if (v > 17'sd8191) begin
      return 14'h1fff;
    end else if (v < -17'sd8192) begin
      return 14'h2000;
    end
    return v[`CM_WORD_W-1:0];
  endfunction

  // Gain as (64 + code) / 64, then signed offset
  function automatic word_t trim_word(word_t w, gain_t g, offs_t o);
    logic [6:0] gm;
    logic signed [22:0] prod;
    logic signed [16:0] sum;
    gm = 7'(g) + `CM_GAIN_UNITY;
    prod = 23'($signed(w)) * 23'($signed({1'b0, gm}));
    sum = 17'(prod >>> `CM_GAIN_SHIFT) + 17'($signed(o));
    return sat_word(sum);
  endfunction

  // High-pass output: word less the running DC estimate
  function automatic word_t hpf_out(word_t w, acc_t a);
    logic signed [16:0] d;
    d = 17'($signed(w)) - 17'($signed(a[`CM_ACC_W-1:`CM_ACC_FRAC]));
    return sat_word(d);
  endfunction

  // DC estimate moves toward the word; corner sets the step
  function automatic acc_t hpf_acc(word_t w, acc_t a,
                                   logic [`CM_CORNER_W-1:0] c);
    logic signed [20:0] diff;
    logic signed [20:0] step;
    diff = 21'($signed({w, 6'h00})) - 21'($signed(a));
    step = diff >>> (4'(c) + 4'h1);
    return acc_t'(21'($signed(a)) + step);
  endfunction

  // Channel served by converter x in the current cycle
  function automatic logic [4:0] chan_of(logic [3:0] x, logic mode16,
                                         logic sel, logic phase);
    // Zero-based: 2x is odd channel 2x+1, 2x+1 is even channel
    return {x, mode16 ? sel : phase};
  endfunction

  // FIFO in the frame path; back-pressure reaches conv_ready
  frame_fifo #(
    .WIDTH($bits(frame_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(st_r.frame_vld),
    .in_data(st_r.frame),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(packer_ready),
    .level(fifo_level)
  );

  // Serialiser: lane l carries converter l only
  lane_packer u_packer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .frm_valid(fifo_out_valid),
    .frm_data(fifo_out_data),
    .frm_ready(packer_ready),
    .serial_lane_out(serial_lane_out),  // [R4]
    .frame_sync(frame_sync)
  );

  // Source may hand a word only when the frame stage is empty or will drain
  assign conv_ready = !st_r.frame_vld || fifo_in_ready;
  assign reg_rdata = st_r.rdata;

  // Power-down fans out from converter, high-pass from four-converter group, to channels
  always_comb begin
    for (int c = 0; c < `CM_CHANNELS; c++) begin
      input_powerdown[c] = st_r.ana_pdn[c/2];             // [R8]
      channel_highpass_enable[c] = st_r.hpf_en[c/8];      // [R9]
    end
  end

  // Registers, conversion path and frame building
  always_comb begin
    logic [4:0] ch;
    logic [1:0] grp;
    logic take;
    logic set_refused;
    logic set_overflow;
    logic set_order;
    word_t w;
    conv_bus_t words;
    ch = '0;
    grp = '0;
    w = '0;
    words = '0;
    set_refused = 1'b0;
    set_overflow = 1'b0;
    set_order = 1'b0;
    take = conv_valid && conv_ready;
    st_nxt = st_r;
    // Read data stand for one cycle only
    st_nxt.rdata = '0;

    // Frame leaves the holding stage when the FIFO takes it
    if (st_r.frame_vld && fifo_in_ready) begin
      st_nxt.frame_vld = 1'b0;
      st_nxt.frames = st_r.frames + 16'h0001;
    end

    // Register writes
    if (reg_req.wr) begin
      if (reg_req.addr == `CM_ADDR_CTRL) begin
        st_nxt.mode16 = reg_req.wdata[`CM_CTRL_MODE16_BIT];
        st_nxt.rate2x = reg_req.wdata[`CM_CTRL_RATE2X_BIT];
        // Doubled rate is refused while 32 inputs are served
        if (!reg_req.wdata[`CM_CTRL_MODE16_BIT] &&
            reg_req.wdata[`CM_CTRL_RATE2X_BIT]) begin
          st_nxt.rate2x = 1'b0;                           // [R1]
          set_refused = 1'b1;                             // [R1]
        end
        // A mode change restarts pairing at an odd word
        if (reg_req.wdata[`CM_CTRL_MODE16_BIT] != st_r.mode16) begin
          st_nxt.odd_seen = 1'b0;                         // [R11]
        end
      end else if (reg_req.addr == `CM_ADDR_DIG_PDN) begin
        st_nxt.dig_pdn = reg_req.wdata;
      end else if (reg_req.addr == `CM_ADDR_ANA_PDN) begin
        st_nxt.ana_pdn = reg_req.wdata;
      end else if (reg_req.addr == `CM_ADDR_IN_SEL) begin
        st_nxt.in_sel = reg_req.wdata;
      end else if (reg_req.addr == `CM_ADDR_HPF_EN) begin
        st_nxt.hpf_en = reg_req.wdata[`CM_GROUPS-1:0];
      end else if (reg_req.addr == `CM_ADDR_HPF_CORNER) begin
        st_nxt.hpf_corner = reg_req.wdata[11:0];
      end else if (reg_req.addr == `CM_ADDR_STATUS) begin
        // Write one to clear; a same-cycle event sets it again below
        if (reg_req.wdata[`CM_STAT_RATE_REFUSED_BIT]) begin
          st_nxt.rate_refused = 1'b0;
        end
        if (reg_req.wdata[`CM_STAT_OVERFLOW_BIT]) begin
          st_nxt.overflow = 1'b0;
        end
        if (reg_req.wdata[`CM_STAT_ORDER_ERR_BIT]) begin
          st_nxt.order_err = 1'b0;
        end
      end else if (reg_req.addr[7:5] == `CM_ADDR_GAIN_BASE) begin
        st_nxt.gain[reg_req.addr[4:0]] = reg_req.wdata[`CM_GAIN_W-1:0];
      end else if (reg_req.addr[7:5] == `CM_ADDR_OFFS_BASE) begin
        st_nxt.offs[reg_req.addr[4:0]] = reg_req.wdata[`CM_OFFS_W-1:0];
      end
    end

    // Register reads; unmapped indices read zero
    if (reg_req.rd) begin
      if (reg_req.addr == `CM_ADDR_CTRL) begin
        st_nxt.rdata = {14'h0000, st_r.rate2x, st_r.mode16};
      end else if (reg_req.addr == `CM_ADDR_DIG_PDN) begin
        st_nxt.rdata = st_r.dig_pdn;
      end else if (reg_req.addr == `CM_ADDR_ANA_PDN) begin
        st_nxt.rdata = st_r.ana_pdn;
      end else if (reg_req.addr == `CM_ADDR_IN_SEL) begin
        st_nxt.rdata = st_r.in_sel;
      end else if (reg_req.addr == `CM_ADDR_HPF_EN) begin
        st_nxt.rdata = {12'h000, st_r.hpf_en};
      end else if (reg_req.addr == `CM_ADDR_HPF_CORNER) begin
        st_nxt.rdata = {4'h0, st_r.hpf_corner};
      end else if (reg_req.addr == `CM_ADDR_STATUS) begin
        st_nxt.rdata = {(8-LW)'(0), fifo_level, 5'h00, st_r.order_err,
                        st_r.overflow, st_r.rate_refused};
      end else if (reg_req.addr == `CM_ADDR_FRAMES) begin
        st_nxt.rdata = st_r.frames;
      end else if (reg_req.addr[7:5] == `CM_ADDR_GAIN_BASE) begin
        st_nxt.rdata = {10'h000, st_r.gain[reg_req.addr[4:0]]};
      end else if (reg_req.addr[7:5] == `CM_ADDR_OFFS_BASE) begin
        st_nxt.rdata = {8'h00, st_r.offs[reg_req.addr[4:0]]};
      end
    end

    // A word offered while the stage is blocked is lost and flagged
    if (conv_valid && !conv_ready) begin
      set_overflow = 1'b1;
    end

    // Trim every converter's word with its own channel's settings
    for (int x = 0; x < `CM_CONVERTERS; x++) begin
      ch = chan_of(4'(x), st_r.mode16, st_r.in_sel[x],
                   conv_phase);                           // [R3] [R10]
      grp = 2'(x / `CM_GROUP_SIZE);
      w = trim_word(conv_word[x], st_r.gain[ch],
                    st_r.offs[ch]);                       // [R6]
      if (st_r.hpf_en[grp]) begin
        // Group enable and corner govern all eight channels
        if (take && !st_r.dig_pdn[x]) begin
          st_nxt.acc[ch] = hpf_acc(w, st_r.acc[ch],
                                   st_r.hpf_corner[grp]); // [R9]
        end
        w = hpf_out(w, st_r.acc[ch]);                     // [R9]
      end
      // Digital power-down silences both channels of the converter
      if (st_r.dig_pdn[x]) begin
        w = '0;                                           // [R7]
      end
      words[x] = w;
    end

    // Frame building
    if (take) begin
      if (st_r.mode16) begin
        // One input per converter, one word per frame
        st_nxt.frame.single = 1'b1;
        st_nxt.frame.odd_w = words;                       // [R10]
        st_nxt.frame.even_w = '0;
        st_nxt.frame_vld = 1'b1;
      end else if (!conv_phase) begin
        // First instant: hold the odd words
        st_nxt.odd_hold = words;                          // [R2] [R3]
        st_nxt.odd_seen = 1'b1;
      end else if (st_r.odd_seen) begin
        // Second instant completes the pair in one frame
        st_nxt.frame.single = 1'b0;
        st_nxt.frame.odd_w = st_r.odd_hold;               // [R5]
        st_nxt.frame.even_w = words;                      // [R5]
        st_nxt.frame_vld = 1'b1;
        st_nxt.odd_seen = 1'b0;                           // [R11]
      end else begin
        // Even word without its odd partner is dropped
        set_order = 1'b1;                                 // [R11]
      end
    end

    // Events win over a same-cycle clear
    if (set_refused) begin
      st_nxt.rate_refused = 1'b1;
    end
    if (set_overflow) begin
      st_nxt.overflow = 1'b1;
    end
    if (set_order) begin
      st_nxt.order_err = 1'b1;
    end
  end

  // State register with synchronous reset to constants
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.mode16 <= 1'(`CM_CTRL_RST >> `CM_CTRL_MODE16_BIT);
      st_r.rate2x <= 1'(`CM_CTRL_RST >> `CM_CTRL_RATE2X_BIT);
      st_r.dig_pdn <= `CM_PDN_RST;
      st_r.ana_pdn <= `CM_PDN_RST;
      st_r.in_sel <= `CM_IN_SEL_RST;
      st_r.hpf_en <= `CM_HPF_EN_RST;
      st_r.hpf_corner <= `CM_HPF_CORNER_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- hw/frame_fifo.sv ----
// Purpose: Flip-flop FIFO between frame builder and lane packer.
// Assumes: One clock; source and sink honour valid and ready.
// Notes: Push and pop may happen in the same cycle when neither empty nor full.
`default_nettype none
module frame_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t st_r;
  fifo_st_t st_nxt;
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign in_ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data = st_r.mem[st_r.rp];
  assign level = st_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    // Count moves only when one side acts alone
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- hw/lane_packer.sv ----
// Purpose: Shifts each frame out, one bit per clock on every lane.
// Assumes: Frames come from the FIFO with valid and ready.
// Notes: Odd word leaves first, MSB first; sync marks the first bit.
`default_nettype none
module lane_packer
  import chan_map_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Frame input
  input wire logic frm_valid,
  input wire chan_map_pkg::frame_t frm_data,
  output logic frm_ready,
  // Serial lanes
  output logic [`CM_CONVERTERS-1:0] serial_lane_out,
  output logic frame_sync
);
  typedef struct packed {
    logic [`CM_CONVERTERS-1:0][2*`CM_WORD_W-1:0] sh;
    logic [4:0] left;
    logic busy;
    logic sync;
  } pack_st_t;
  pack_st_t st_r;
  pack_st_t st_nxt;

  // A new frame may load on the last bit of the current one
  assign frm_ready = !st_r.busy || (st_r.left == 5'h00);

  // Lane bits come straight from the shift register tops
  always_comb begin
    for (int l = 0; l < `CM_CONVERTERS; l++) begin
      serial_lane_out[l] = st_r.sh[l][2*`CM_WORD_W-1];
    end
  end
  assign frame_sync = st_r.sync;

  // Load, shift and count down
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync = 1'b0;
    if (st_r.busy) begin
      for (int l = 0; l < `CM_CONVERTERS; l++) begin
        st_nxt.sh[l] = {st_r.sh[l][2*`CM_WORD_W-2:0], 1'b0};
      end
      st_nxt.left = st_r.left - 5'h01;
      if (st_r.left == 5'h00) begin
        st_nxt.busy = 1'b0;
      end
    end
    if (frm_valid && frm_ready) begin
      // Odd word ahead of even word on the same lane [R5]
      for (int l = 0; l < `CM_CONVERTERS; l++) begin
        st_nxt.sh[l] = {frm_data.odd_w[l], frm_data.even_w[l]};
      end
      st_nxt.left = frm_data.single ? `CM_FRAME_BITS_ONE
                                    : `CM_FRAME_BITS_TWO;
      st_nxt.busy = 1'b1;
      st_nxt.sync = 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/chan_mapper_sva.sv ----
// Purpose: Port checks for the channel mapper.
// Assumes: One clock; bound into chan_mapper.
// Notes: Register checks rely on write-then-read pairs.
`default_nettype none
module chan_mapper_sva
  import chan_map_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire chan_map_pkg::reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  // Converter side
  input wire logic conv_valid,
  input wire logic conv_ready,
  // Derived outputs
  input wire logic frame_sync,
  input wire logic [31:0] input_powerdown,
  input wire logic [31:0] channel_highpass_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Doubled rate asked in 32-input mode must not be stored
  rate_refuse_a: assert property (
    (reg_req.wr && reg_req.addr == 8'h00 && reg_req.wdata[1:0] == 2'h2)
    ##1 (reg_req.rd && reg_req.addr == 8'h00) |=> reg_rdata[1:0] == 2'h0)
    else $error("doubled rate stored");
  rate_read_a: assert property (
    reg_req.rd && reg_req.addr == 8'h00 |=> reg_rdata[1:0] != 2'h2)
    else $error("control shows doubled rate");
  gain_keep_a: assert property (
    (reg_req.wr && reg_req.addr == 8'h40)
    ##1 (reg_req.rd && reg_req.addr == 8'h40)
    |=> reg_rdata == {10'h000, $past(reg_req.wdata[5:0], 2)})
    else $error("channel gain lost");
  // Both inputs of a converter always share one power-down
  pdn_pair_a: assert property (
    ((input_powerdown >> 1) & 32'h55555555) ==
    (input_powerdown & 32'h55555555))
    else $error("power-down pair split");
  pdn_reg_a: assert property (
    reg_req.wr && reg_req.addr == 8'h02 |=>
    input_powerdown[31:30] == {2{$past(reg_req.wdata[15])}})
    else $error("power-down not applied");
  // A high-pass group spans eight channels
  hpf_group_a: assert property (
    channel_highpass_enable == {{8{channel_highpass_enable[24]}},
    {8{channel_highpass_enable[16]}}, {8{channel_highpass_enable[8]}},
    {8{channel_highpass_enable[0]}}})
    else $error("high-pass group split");
  hpf_reg_a: assert property (
    reg_req.wr && reg_req.addr == 8'h04 |=>
    channel_highpass_enable[15:8] == {8{$past(reg_req.wdata[1])}})
    else $error("high-pass enable not applied");
  // Two words a frame leave no room for a sync soon after
  sync_gap_a: assert property (
    frame_sync |=> !frame_sync [*8])
    else $error("frame too short");
  cover property (frame_sync);
  cover property (conv_valid && !conv_ready);
  cover property (reg_req.wr && reg_req.addr == 8'h02);
endmodule
bind chan_mapper chan_mapper_sva chan_mapper_sva_i (
  .sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .conv_valid(conv_valid),
  .conv_ready(conv_ready), .frame_sync(frame_sync),
  .input_powerdown(input_powerdown),
  .channel_highpass_enable(channel_highpass_enable));
`default_nettype wire

// ---- testbench/lane_receiver.sv ----
// Purpose: Receiver model rebuilding each lane's frame.
// Assumes: Sync marks the odd word MSB; 28 bits a frame.
// Notes: Words told apart by position only; no 16-input frames.
`default_nettype none
module lane_receiver (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial lanes
  input wire logic [15:0] lane,
  input wire logic sync,
  // Rebuilt frames, odd word in the upper half
  output logic [15:0][27:0] cap,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0][27:0] sh; // One shift register a lane
  logic [4:0] cnt; // Bits taken in this frame
  // One bit a lane each clock; a sync restarts the frame
  always_ff @(posedge sys_clk) begin
    done <= 1'b0;
    if (!resetn) begin
      cnt <= 5'h00;
    end else if (sync || cnt != 5'h00) begin
      for (int l = 0; l < 16; l++) begin
        sh[l] <= {sh[l][26:0], lane[l]};
        if (!sync && cnt == 5'h1b) cap[l] <= {sh[l][26:0], lane[l]};
      end
      done <= !sync && cnt == 5'h1b;
      cnt <= sync ? 5'h01 : (cnt == 5'h1b ? 5'h00 : cnt + 5'h01);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_chan_mapper.sv ----
// Purpose: Self-checking bench for the channel mapper.
// Assumes: Receiver model rebuilds 28-bit lane frames.
// Notes: Settings go back to zero after each test, except input select left at 1 by the trim test.
`default_nettype none
module tb_chan_mapper
  import chan_map_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0; // 10 MHz
  logic resetn = 1'b0; // Held low 16 cycles
  reg_req_t reg_req = '0;
  logic [15:0] reg_rdata;
  logic conv_valid = 1'b0;
  logic conv_phase = 1'b0;
  conv_bus_t conv_word = '0;
  logic conv_ready;
  logic [15:0] lane;
  logic sync;
  logic [31:0] pdn;
  logic [31:0] hpf;
  logic [15:0][27:0] cap; // Frames seen by the receiver
  logic done;
  int errors = 0;
  int checked = 0;
  always #50 sys_clk = ~sys_clk;
  chan_mapper #(.FIFO_DEPTH(16)) chan_mapper_i (
    .sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .conv_valid(conv_valid),
    .conv_phase(conv_phase), .conv_word(conv_word),
    .conv_ready(conv_ready), .serial_lane_out(lane),
    .frame_sync(sync), .input_powerdown(pdn),
    .channel_highpass_enable(hpf));
  lane_receiver lane_receiver_i (.sys_clk(sys_clk), .resetn(resetn),
    .lane(lane), .sync(sync), .cap(cap), .done(done));
  // Mismatches show at once; four-state compare
  task automatic cmp(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Data stand only in the cycle after the read strobe
  task automatic rget(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 d = reg_rdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rget(a, d);
    cmp($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, d});
  endtask
  // Write, then read straight back with no gap
  task automatic wrd(input logic [7:0] a, input logic [15:0] d,
    input logic [15:0] e);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    rd(a, e);
  endtask
  function automatic conv_bus_t mk(input logic [13:0] b);
    for (int l = 0; l < 16; l++) mk[l] = b + 14'(l);
  endfunction
  // Odd word then even word; every lane compared whole
  task automatic frame(input conv_bus_t o, input conv_bus_t e,
    input conv_bus_t xo, input conv_bus_t xe);
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    conv_phase <= 1'b0;
    conv_word <= o;
    @(posedge sys_clk);
    conv_phase <= 1'b1;
    conv_word <= e;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    for (int i = 0; i < 80 && done !== 1'b1; i++) @(posedge sys_clk);
    cmp("frame done", 1, {31'h0, done});
    for (int l = 0; l < 16; l++)
      cmp($sformatf("lane %0d", l), {xo[l], xe[l]}, cap[l]);
  endtask
  task automatic t_regs;
    rd(8'h06, 16'h0000);
    rd(8'h20, 16'h0000);
    wrd(8'h00, 16'h0002, 16'h0000);
    rd(8'h06, 16'h0001);
    wrd(8'h06, 16'h0001, 16'h0000);
    wrd(8'h00, 16'h0003, 16'h0003);
    wrd(8'h00, 16'h0000, 16'h0000);
    $display("test regs over");
  endtask
  task automatic t_map;
    frame(mk(14'h0100), mk(14'h0200), mk(14'h0100), mk(14'h0200));
    frame(mk(14'h1ff0), mk(14'h2000), mk(14'h1ff0), mk(14'h2000));
    $display("test map over");
  endtask
  task automatic t_trim;
    conv_bus_t xo;
    conv_bus_t xe;
    xo = mk(14'h0040);
    xe = mk(14'h0080);
    xo[1] = 14'h0061; // 0x41 times 96/64, rounded down
    xe[0] = 14'h0085; // Offset 5 on channel 2 only
    wrd(8'h61, 16'h0005, 16'h0005);
    wrd(8'h42, 16'h0020, 16'h0020);
    frame(mk(14'h0040), mk(14'h0080), xo, xe);
    wrd(8'h00, 16'h0001, 16'h0001);
    wrd(8'h03, 16'h0001, 16'h0001);
    xe[1] = 14'h00c1;
    frame(mk(14'h0040), mk(14'h0080), xe, '0);
    wrd(8'h00, 16'h0000, 16'h0000);
    wrd(8'h61, 16'h0000, 16'h0000);
    wrd(8'h42, 16'h0000, 16'h0000);
    wrd(8'h40, 16'hffff, 16'h003f);
    wrd(8'h40, 16'h0000, 16'h0000);
    $display("test trim over");
  endtask
  task automatic t_power;
    conv_bus_t xo;
    conv_bus_t xe;
    xo = mk(14'h0300);
    xe = mk(14'h0400);
    xo[1] = 14'h0000;
    xe[1] = 14'h0000;
    wrd(8'h02, 16'h8001, 16'h8001);
    cmp("powerdown", 32'hc0000003, pdn);
    wrd(8'h02, 16'h0000, 16'h0000);
    wrd(8'h01, 16'h0002, 16'h0002);
    frame(mk(14'h0300), mk(14'h0400), xo, xe);
    wrd(8'h01, 16'h0000, 16'h0000);
    wrd(8'h04, 16'h0002, 16'h0002);
    cmp("highpass", 32'h0000ff00, hpf);
    wrd(8'h05, 16'hffff, 16'h0fff);
    wrd(8'h04, 16'h0000, 16'h0000);
    wrd(8'h05, 16'h0000, 16'h0000);
    $display("test power over");
  endtask
  // Fill the buffer until refused, then let it drain
  task automatic t_fill;
    logic [15:0] d;
    int n;
    n = 0;
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    conv_phase <= 1'b0;
    while (n < 100) begin
      @(posedge sys_clk);
      n++;
      if (conv_ready !== 1'b1) break;
      conv_phase <= ~conv_phase;
    end
    conv_valid <= 1'b0;
    cmp("refused", 1, {31'h0, n < 100});
    rget(8'h06, d);
    cmp("overflow", 16'h0002, {16'h0, d & 16'h0002});
    for (n = 0; n < 800 && d[12:8] !== 5'h00; n++) rget(8'h06, d);
    cmp("drained", 16'h0002, {16'h0, d});
    wrd(8'h06, 16'h0002, 16'h0000);
    $display("test fill over");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    cmp("reset powerdown", 0, pdn);
    t_regs();
    t_map();
    t_trim();
    t_power();
    t_fill();
    conclude();
  end
  // Whole run needs about 750 cycles
  initial begin
    repeat (6000) @(posedge sys_clk);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
